/* afs_map.svh */
`ifndef AFS_MAP_SVH
`define AFS_MAP_SVH
// Behaviour
// - status bit 7 shows a failed memory integrity check
// - status bit 6 shows the last coefficient write failed
// - thermal shutdown status bit 0; bits 7-1 read zero
// - warning register bit 2 shows die at 135 C warning level
// - mask bit 7 hides thermal shutdown from fault report; resets zero
// - mask bit 6 hides logic supply undervoltage from fault report
// - mask bit 5 hides logic supply overvoltage from fault report
// - status bit 2 flags clock fault; mask bit 4 hides its report
// - status bit 0 flags power supply undervoltage; mask bit 3 hides it
// - status bit 1 flags power supply overvoltage; mask bit 2 hides it
// - mask bit 1 hides output dc faults from fault report
// - mask bit 0 hides overcurrent faults from fault report
// - latch bit 5, set at reset, makes clock faults sticky
// - latch bit 4, set at reset, makes thermal shutdown sticky
// - latch bit 3, set at reset, makes thermal warning sticky
// - latch bit 2 hides warning report; resets zero, bits 7-6 ones
// - misc bit 7 latches clock detect status, else it follows live
// - misc bit 4 enables automatic thermal shutdown recovery; resets zero
// - writing one to clear bit 7 clears latched analog faults

// ****************************************
// offsets
// ****************************************
`define AFS_OFS_SUPPLY 8'h71
`define AFS_OFS_TSD 8'h72
`define AFS_OFS_WARN 8'h73
`define AFS_OFS_MASK 8'h74
`define AFS_OFS_LATCH 8'h75
`define AFS_OFS_MISC 8'h76
`define AFS_OFS_HP 8'h77
`define AFS_OFS_CLEAR 8'h78

// ****************************************
// fields
// ****************************************
`define AFS_THERMAL_SHUTDOWN_MASK 7
`define AFS_MASK_LUV 6
`define AFS_MASK_LOV 5
`define AFS_MASK_CLK 4
`define AFS_MASK_PUV 3
`define AFS_MASK_POV 2
`define AFS_OUTPUT_DC_FAULT_MASK 1
`define AFS_OVERCURRENT_MASK 0
`define AFS_LATCH_CLK 5
`define AFS_LATCH_OTSD 4
`define AFS_LATCH_OTW 3
`define AFS_LATCH_THERMAL_WARNING_MASK 2
`define AFS_MISC_DET_LATCH 7
`define AFS_MISC_AUTO_REC 4
`define AFS_HP_UNMUTE 2
`define AFS_HP_ENABLE 1
`define AFS_CLEAR_ANALOG 7
`define AFS_WARN_DEGC 135

// ****************************************
// reset values
// ****************************************
`define AFS_RST_MASK 8'h00
`define AFS_RST_LATCH 8'hF8
`define AFS_RST_MISC 8'h00
`define AFS_RST_HP 8'h00
`define AFS_RST_CLEAR 7'h00
`endif

/* afs_pkg.sv */
package afs_pkg;
  typedef enum logic {
    AFS_TSD_NORMAL,
    AFS_TSD_TRIPPED
  } afs_tsd_state_t;

  typedef struct packed {
    logic flag;
  } afs_cell_st_t;

  typedef struct packed {
    afs_tsd_state_t state;
  } afs_tsd_st_t;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] latch_ctl;
    logic [7:0] misc;
    logic [7:0] hp;
    logic [6:0] clr_rsv;
    logic clr_pulse;
    logic otp_err;
    logic coef_err;
    logic [7:0] rdata;
    logic report;
  } afs_top_st_t;
endpackage

/* afs_fault_cell.sv */
`timescale 1ns/100ps
module afs_fault_cell
  import afs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic cond_i,
  input wire logic latch_en_i,
  input wire logic clear_i,
  output logic flag_o
);
  afs_cell_st_t st;
  afs_cell_st_t next_st;

  // live condition beats a clear in the same cycle
  always_comb begin
    next_st = st;
    if (cond_i) begin
      next_st.flag = 1'b1;
    end else if (clear_i || !latch_en_i) begin
      next_st.flag = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag_o = st.flag;
endmodule // afs_fault_cell

/* afs_tsd_ctrl.sv */
`timescale 1ns/100ps
module afs_tsd_ctrl
  import afs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic cond_i,
  input wire logic latch_en_i,
  input wire logic auto_rec_i,
  input wire logic clear_i,
  output logic shutdown_o
);
  afs_tsd_st_t st;
  afs_tsd_st_t next_st;

  always_comb begin
    next_st = st;
    case (st.state)
      AFS_TSD_NORMAL: begin
        if (cond_i) begin
          next_st.state = AFS_TSD_TRIPPED;
        end
      end
      AFS_TSD_TRIPPED: begin
        // never leave while the die is still hot
        if (!cond_i && (auto_rec_i || clear_i || !latch_en_i)) begin
          next_st.state = AFS_TSD_NORMAL;
        end
      end
      default: begin
        next_st.state = AFS_TSD_NORMAL;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign shutdown_o = (st.state == AFS_TSD_TRIPPED);
endmodule // afs_tsd_ctrl

/* afs_fault_bank.sv */
`timescale 1ns/100ps
`include "afs_map.svh"
module afs_fault_bank
  import afs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic otp_crc_fail_i,
  input wire logic filter_coef_write_error_i,
  input wire logic clock_fault_i,
  input wire logic clock_detect_i,
  input wire logic power_supply_undervolt_i,
  input wire logic power_supply_overvolt_i,
  input wire logic logic_supply_undervolt_i,
  input wire logic logic_supply_overvolt_i,
  input wire logic thermal_shutdown_i,
  input wire logic thermal_warning_i,
  input wire logic output_dc_fault_i,
  input wire logic overcurrent_i,
  output logic fault_report_o,
  output logic power_stage_shutdown_o,
  output logic clock_detect_status_o,
  output logic analog_fault_clear_o,
  output logic [4:0] headphone_gain_o,
  output logic headphone_unmute_o,
  output logic headphone_enable_n_shutdown_o
);
  localparam int NCELL = 5;
  localparam int C_CLK = 0;
  localparam int C_OTW = 1;
  localparam int C_PUV = 2;
  localparam int C_POV = 3;
  localparam int C_DET = 4;

  afs_top_st_t st;
  afs_top_st_t next_st;
  logic [NCELL-1:0] cell_cond;
  logic [NCELL-1:0] cell_le;
  logic [NCELL-1:0] cell_flag;
  logic tsd_flag;

  // ****************************************
  // sticky or live fault flags
  // ****************************************
  // power supply faults always hold until cleared, so short dips are seen
  assign cell_cond[C_CLK] = clock_fault_i;
  assign cell_cond[C_OTW] = thermal_warning_i;
  assign cell_cond[C_PUV] = power_supply_undervolt_i;
  assign cell_cond[C_POV] = power_supply_overvolt_i;
  assign cell_cond[C_DET] = clock_detect_i;
  assign cell_le[C_CLK] = st.latch_ctl[`AFS_LATCH_CLK];
  assign cell_le[C_OTW] = st.latch_ctl[`AFS_LATCH_OTW];
  assign cell_le[C_PUV] = 1'b1;
  assign cell_le[C_POV] = 1'b1;
  assign cell_le[C_DET] = st.misc[`AFS_MISC_DET_LATCH];

  genvar gi;
  generate
    for (gi = 0; gi < NCELL; gi++) begin : g_cell
      afs_fault_cell u_cell (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .cond_i(cell_cond[gi]),
        .latch_en_i(cell_le[gi]),
        .clear_i(st.clr_pulse),
        .flag_o(cell_flag[gi])
      );
    end
  endgenerate

  afs_tsd_ctrl u_tsd (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .cond_i(thermal_shutdown_i),
    .latch_en_i(st.latch_ctl[`AFS_LATCH_OTSD]),
    .auto_rec_i(st.misc[`AFS_MISC_AUTO_REC]),
    .clear_i(st.clr_pulse),
    .shutdown_o(tsd_flag)
  );

  // ****************************************
  // register port
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.clr_pulse = 1'b0;
    next_st.otp_err = otp_crc_fail_i;
    next_st.coef_err = filter_coef_write_error_i;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `AFS_OFS_MASK: next_st.mask = reg_wdata_i;
        `AFS_OFS_LATCH: next_st.latch_ctl = reg_wdata_i;
        `AFS_OFS_MISC: next_st.misc = reg_wdata_i;
        `AFS_OFS_HP: next_st.hp = reg_wdata_i;
        `AFS_OFS_CLEAR: begin
          next_st.clr_rsv = reg_wdata_i[6:0];
          next_st.clr_pulse = reg_wdata_i[`AFS_CLEAR_ANALOG];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `AFS_OFS_SUPPLY: begin
          next_st.rdata = {st.otp_err, st.coef_err, 3'h0,
                           cell_flag[C_CLK], cell_flag[C_POV],
                           cell_flag[C_PUV]};
        end
        `AFS_OFS_TSD: next_st.rdata = {7'h00, tsd_flag};
        `AFS_OFS_WARN: next_st.rdata = {5'h00, cell_flag[C_OTW], 2'h0};
        `AFS_OFS_MASK: next_st.rdata = st.mask;
        `AFS_OFS_LATCH: next_st.rdata = st.latch_ctl;
        `AFS_OFS_MISC: next_st.rdata = st.misc;
        `AFS_OFS_HP: next_st.rdata = st.hp;
        // clear bit is write only and reads back zero
        `AFS_OFS_CLEAR: next_st.rdata = {1'b0, st.clr_rsv};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // ****************************************
    // fault report
    // ****************************************
    // status bits keep the raw flags; masks only gate the report
    next_st.report =
      (tsd_flag && !st.mask[`AFS_THERMAL_SHUTDOWN_MASK]) ||
      (logic_supply_undervolt_i && !st.mask[`AFS_MASK_LUV]) ||
      (logic_supply_overvolt_i && !st.mask[`AFS_MASK_LOV]) ||
      (cell_flag[C_CLK] && !st.mask[`AFS_MASK_CLK]) ||
      (cell_flag[C_PUV] && !st.mask[`AFS_MASK_PUV]) ||
      (cell_flag[C_POV] && !st.mask[`AFS_MASK_POV]) ||
      (output_dc_fault_i && !st.mask[`AFS_OUTPUT_DC_FAULT_MASK]) ||
      (overcurrent_i && !st.mask[`AFS_OVERCURRENT_MASK]) ||
      (cell_flag[C_OTW] && !st.latch_ctl[`AFS_LATCH_THERMAL_WARNING_MASK]);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
      st.mask <= `AFS_RST_MASK;
      st.latch_ctl <= `AFS_RST_LATCH;
      st.misc <= `AFS_RST_MISC;
      st.hp <= `AFS_RST_HP;
      st.clr_rsv <= `AFS_RST_CLEAR;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign fault_report_o = st.report;
  assign power_stage_shutdown_o = tsd_flag;
  assign clock_detect_status_o = cell_flag[C_DET];
  assign analog_fault_clear_o = st.clr_pulse;
  // reserved gain codes pass through unchanged; the driver saturates them
  assign headphone_gain_o = st.hp[7:3];
  assign headphone_unmute_o = st.hp[`AFS_HP_UNMUTE];
  assign headphone_enable_n_shutdown_o = st.hp[`AFS_HP_ENABLE];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence

  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence

  sequence s_clr_wr;
    reg_wr_i && reg_addr_i == `AFS_OFS_CLEAR && reg_wdata_i[`AFS_CLEAR_ANALOG];
  endsequence

  a_otp_read: assert property (otp_crc_fail_i ##1 s_rd(`AFS_OFS_SUPPLY)
    |=> reg_rdata_o[7]) else $error("otp error not read");
  a_coef_read: assert property (filter_coef_write_error_i
    ##1 s_rd(`AFS_OFS_SUPPLY) |=> reg_rdata_o[6])
    else $error("coef error not read");
  a_tsd_read: assert property (s_rd(`AFS_OFS_TSD)
    |=> reg_rdata_o == {7'h00, $past(power_stage_shutdown_o)})
    else $error("tsd status wrong");
  a_otw_set_read: assert property (thermal_warning_i
    ##1 s_rd(`AFS_OFS_WARN) |=> reg_rdata_o == 8'h04)
    else $error("warning not read");
  a_otsd_report: assert property ((tsd_flag
    && !st.mask[`AFS_THERMAL_SHUTDOWN_MASK]) |=> fault_report_o)
    else $error("tsd not reported");
  a_luv_report: assert property ((logic_supply_undervolt_i
    && !st.mask[`AFS_MASK_LUV]) |=> fault_report_o)
    else $error("logic uv not reported");
  a_lov_report: assert property ((logic_supply_overvolt_i
    && !st.mask[`AFS_MASK_LOV]) |=> fault_report_o)
    else $error("logic ov not reported");
  a_clk_flag: assert property (clock_fault_i ##1 s_rd(`AFS_OFS_SUPPLY)
    |=> reg_rdata_o[2]) else $error("clock fault lost");
  a_puv_sticky: assert property (power_supply_undervolt_i
    ##1 (!st.clr_pulse)[*2] |-> cell_flag[C_PUV])
    else $error("power_stage_supply uv dropped");
  a_pov_report: assert property ((cell_flag[C_POV]
    && !st.mask[`AFS_MASK_POV]) |=> fault_report_o)
    else $error("power_stage_supply ov not reported");
  a_dc_report: assert property ((output_dc_fault_i
    && !st.mask[`AFS_OUTPUT_DC_FAULT_MASK]) |=> fault_report_o)
    else $error("dc not reported");
  a_oc_report: assert property ((overcurrent_i
    && !st.mask[`AFS_OVERCURRENT_MASK]) |=> fault_report_o)
    else $error("oc not reported");
  a_all_masked: assert property ((st.mask == 8'hFF
    && st.latch_ctl[`AFS_LATCH_THERMAL_WARNING_MASK] && cell_flag == '0
    && !tsd_flag) |=> !fault_report_o)
    else $error("masked fault reported");
  a_clk_latch: assert property ((cell_le[C_CLK] && cell_flag[C_CLK]
    && !st.clr_pulse) |=> cell_flag[C_CLK])
    else $error("clock fault not held");
  a_clk_follow: assert property ((!cell_le[C_CLK] && !clock_fault_i)
    |=> !cell_flag[C_CLK]) else $error("clock fault held");
  a_tsd_latch: assert property ((tsd_flag && st.latch_ctl[`AFS_LATCH_OTSD]
    && !st.misc[`AFS_MISC_AUTO_REC] && !st.clr_pulse) |=> tsd_flag)
    else $error("tsd not held");
  a_otw_latch: assert property ((cell_le[C_OTW] && cell_flag[C_OTW]
    && !st.clr_pulse) |=> cell_flag[C_OTW])
    else $error("warning not held");
  a_det_follow: assert property ((!cell_le[C_DET])
    |=> clock_detect_status_o == $past(clock_detect_i))
    else $error("detect not live");
  a_auto_rec: assert property ((tsd_flag && st.misc[`AFS_MISC_AUTO_REC]
    && !thermal_shutdown_i) |=> !tsd_flag)
    else $error("no auto recovery");
  a_clear_seq: assert property (s_clr_wr ##1 !clock_fault_i
    |=> !cell_flag[C_CLK])
    else $error("clear had no effect");
  a_clear_pulse: assert property (analog_fault_clear_o
    |-> $past(reg_wr_i) && $past(reg_wdata_i[7]))
    else $error("stray clear pulse");
  a_hp_write: assert property (s_wr(`AFS_OFS_HP) |=>
    headphone_gain_o == $past(reg_wdata_i[7:3])
    && headphone_unmute_o == $past(reg_wdata_i[2])
    && headphone_enable_n_shutdown_o == $past(reg_wdata_i[1]))
    else $error("headphone field wrong");
  a_unmapped: assert property ((reg_rd_i && reg_addr_i < `AFS_OFS_SUPPLY)
    |=> reg_rdata_o == 8'h00) else $error("unmapped read nonzero");

  // ****************************************
  // flag, report, clear and register checks
  // ****************************************
  // hot die must never be released, even with recovery on
  a_tsd_set: assert property (thermal_shutdown_i
    |=> power_stage_shutdown_o) else $error("tsd not set");
  a_otw_report: assert property ((cell_flag[C_OTW]
    && !st.latch_ctl[`AFS_LATCH_THERMAL_WARNING_MASK]) |=> fault_report_o)
    else $error("warning not reported");
  a_clk_report: assert property ((cell_flag[C_CLK]
    && !st.mask[`AFS_MASK_CLK]) |=> fault_report_o)
    else $error("clock fault not reported");
  a_puv_report: assert property ((cell_flag[C_PUV]
    && !st.mask[`AFS_MASK_PUV]) |=> fault_report_o)
    else $error("power_stage_supply uv not reported");
  a_pov_flag: assert property (power_supply_overvolt_i
    |=> cell_flag[C_POV]) else $error("power_stage_supply ov not flagged");
  a_otw_live: assert property ((!cell_le[C_OTW] && !thermal_warning_i)
    |=> !cell_flag[C_OTW])
    else $error("warning held");
  a_tsd_follow: assert property ((tsd_flag
    && !st.latch_ctl[`AFS_LATCH_OTSD] && !thermal_shutdown_i)
    |=> !tsd_flag) else $error("tsd held");
  a_det_latch: assert property ((cell_le[C_DET] && cell_flag[C_DET]
    && !st.clr_pulse) |=> clock_detect_status_o)
    else $error("detect not held");
  a_tsd_hot: assert property ((tsd_flag && thermal_shutdown_i)
    |=> tsd_flag) else $error("tsd left while hot");
  a_clear_reads_zero: assert property (s_rd(`AFS_OFS_CLEAR)
    |=> !reg_rdata_o[7]) else $error("clear bit read one");
  a_rdata_hold: assert property (!reg_rd_i
    |=> $stable(reg_rdata_o)) else $error("read data moved");
  a_puv_clear: assert property ((st.clr_pulse
    && !power_supply_undervolt_i) |=> !cell_flag[C_PUV])
    else $error("power_stage_supply uv not cleared");
  a_pov_clear: assert property ((st.clr_pulse
    && !power_supply_overvolt_i) |=> !cell_flag[C_POV])
    else $error("power_stage_supply ov not cleared");
  a_mask_write: assert property (s_wr(`AFS_OFS_MASK)
    |=> st.mask == $past(reg_wdata_i))
    else $error("mask write lost");
  a_latch_write: assert property (s_wr(`AFS_OFS_LATCH)
    |=> st.latch_ctl == $past(reg_wdata_i))
    else $error("latch write lost");
  a_misc_write: assert property (s_wr(`AFS_OFS_MISC)
    |=> st.misc == $past(reg_wdata_i))
    else $error("misc write lost");
  a_ro_ignored: assert property (s_wr(`AFS_OFS_SUPPLY)
    |=> $stable(st.mask) && $stable(st.latch_ctl)
    && $stable(st.misc) && $stable(st.hp))
    else $error("status write changed control");
  a_report_quiet: assert property ((!tsd_flag && !cell_flag[C_CLK]
    && !cell_flag[C_PUV] && !cell_flag[C_POV] && !cell_flag[C_OTW]
    && !logic_supply_undervolt_i && !logic_supply_overvolt_i
    && !output_dc_fault_i && !overcurrent_i)
    |=> !fault_report_o)
    else $error("report without fault");
endmodule // afs_fault_bank

/* afs_host_model.sv */
`timescale 1ns/100ps
module afs_host_model (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // ****************************************
  // control port cycles
  // ****************************************
  // idle lines flip so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge core_clk_i);
    #1 d = reg_rdata_i;
  endtask

  // release latched faults
  task automatic clear_faults();
    wr_reg(8'h78, 8'h80);
  endtask
endmodule // afs_host_model

/* tb.sv */
`timescale 1ns/100ps
`define CHK(n, g, e) chk(n, 8'(e), 8'(g))
module tb;
  import afs_pkg::*;
  logic core_clk_i;
  logic arst_n_i;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [11:0] flt;
  logic report;
  logic shutdown;
  logic det;
  logic clr;
  logic [4:0] gain;
  logic unmute;
  logic hp_en;
  logic [7:0] d;
  logic [7:0] m;
  logic [11:0] f;
  int mismatches;
  int comparisons;
  int pulses;
  int seed;
  int p;

  afs_host_model host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

  afs_fault_bank dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .otp_crc_fail_i(flt[11]),
    .filter_coef_write_error_i(flt[10]), .clock_detect_i(flt[9]),
    .thermal_warning_i(flt[8]), .thermal_shutdown_i(flt[7]),
    .logic_supply_undervolt_i(flt[6]), .logic_supply_overvolt_i(flt[5]),
    .clock_fault_i(flt[4]), .power_supply_undervolt_i(flt[3]),
    .power_supply_overvolt_i(flt[2]), .output_dc_fault_i(flt[1]),
    .overcurrent_i(flt[0]), .fault_report_o(report),
    .power_stage_shutdown_o(shutdown), .clock_detect_status_o(det),
    .analog_fault_clear_o(clr), .headphone_gain_o(gain),
    .headphone_unmute_o(unmute), .headphone_enable_n_shutdown_o(hp_en));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) if (clr === 1'b1) pulses++;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    host.rd_reg(a, d);
    `CHK($sformatf("reg %h", a), d, e);
  endtask

  task automatic setf(logic [11:0] v);
    @(posedge core_clk_i) flt <= v;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  // masks only gate the report; status shows raw flags
  function automatic logic [7:0] exp_st(logic [11:0] v);
    return {v[11], v[10], 3'b000, v[4], v[2], v[3]};
  endfunction

  function automatic logic exp_rep(logic [11:0] v, logic [7:0] k);
    return (|(v[7:0] & ~k)) | v[8];
  endfunction

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk_i);
    mismatches++;
    close_out();
  end

  initial begin
    seed = 48;
    mismatches = 0;
    comparisons = 0;
    pulses = 0;
    flt = 12'h000;
    arst_n_i = 1'b0;
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    // ****************************************
    // reset values, unmapped 0x70 and 0x79
    // ****************************************
    for (int a = 8'h70; a < 8'h7A; a++)
      rd_chk(8'(a), (a == 8'h75) ? 8'hF8 : 8'h00);
    `CHK("hp reset", {gain, unmute, hp_en}, 8'h00);
    $display("test reset done");
    // read only status ignores writes; rw bytes read back
    for (int i = 0; i < 12; i++) begin
      m = 8'h74 + 8'(i % 6);
      d = 8'($random(seed));
      if (m == 8'h78) d[7] = 1'b0;
      if (m == 8'h79) m = 8'h71;
      host.wr_reg(m, d);
      rd_chk(m, (m == 8'h71) ? 8'h00 : d);
    end
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 8'h86 : (k == 1) ? 8'hC6 : (k == 2) ? 8'hFE : 8'h00;
      host.wr_reg(8'h77, d);
      // outputs move at the write edge itself; look once they settle
      #1;
      `CHK("hp outputs", {gain, unmute, hp_en}, d[7:1]);
    end
    host.wr_reg(8'h74, 8'h00);
    host.wr_reg(8'h75, 8'hF8);
    host.wr_reg(8'h76, 8'h00);
    $display("test registers done");
    // ****************************************
    // sticky faults, clear while present
    // ****************************************
    setf(12'hD9C);
    rd_chk(8'h71, 8'hC7);
    rd_chk(8'h72, 8'h01);
    rd_chk(8'h73, 8'h04);
    host.clear_faults();
    rd_chk(8'h71, 8'hC7);
    setf(12'h000);
    rd_chk(8'h71, 8'h07);
    rd_chk(8'h72, 8'h01);
    rd_chk(8'h73, 8'h04);
    `CHK("shutdown held", shutdown, 1);
    p = pulses;
    host.clear_faults();
    setf(12'h000);
    `CHK("clear pulses", pulses, p + 1);
    rd_chk(8'h71, 8'h00);
    rd_chk(8'h72, 8'h00);
    `CHK("shutdown off", shutdown, 0);
    // latches off: clock, shutdown and warning flags follow the live conditions
    host.wr_reg(8'h75, 8'hC0);
    setf(12'h190);
    rd_chk(8'h71, 8'h04);
    setf(12'h000);
    rd_chk(8'h71, 8'h00);
    rd_chk(8'h72, 8'h00);
    rd_chk(8'h73, 8'h00);
    host.wr_reg(8'h75, 8'hF8);
    $display("test latching done");
    // ****************************************
    // each mask against its own fault
    // ****************************************
    for (int b = 0; b < 9; b++) begin
      setf(12'h001 << b);
      `CHK("report on", report, 1);
      if (b == 8) host.wr_reg(8'h75, 8'hFC);
      else host.wr_reg(8'h74, 8'h01 << b);
      setf(12'h001 << b);
      `CHK("report masked", report, 0);
      setf(12'h000);
      host.wr_reg(8'h74, 8'h00);
      host.wr_reg(8'h75, 8'hF8);
      host.clear_faults();
      setf(12'h000);
      `CHK("report idle", report, 0);
    end
    // random fault patterns under random masks
    for (int i = 0; i < 8; i++) begin
      f = 12'($random(seed)) & 12'hDFF;
      m = 8'($random(seed));
      host.wr_reg(8'h74, m);
      setf(f);
      `CHK("report mix", report, exp_rep(f, m));
      rd_chk(8'h71, exp_st(f));
      setf(12'h000);
      host.wr_reg(8'h74, 8'h00);
      host.clear_faults();
      setf(12'h000);
    end
    $display("test masks done");
    // ****************************************
    // auto recovery and clock detect
    // ****************************************
    host.wr_reg(8'h76, 8'h10);
    setf(12'h080);
    `CHK("shutdown on", shutdown, 1);
    setf(12'h000);
    `CHK("auto recover", shutdown, 0);
    host.wr_reg(8'h76, 8'h00);
    setf(12'h200);
    `CHK("detect live", det, 1);
    setf(12'h000);
    `CHK("detect drop", det, 0);
    host.wr_reg(8'h76, 8'h80);
    setf(12'h200);
    setf(12'h000);
    `CHK("detect held", det, 1);
    host.clear_faults();
    setf(12'h000);
    `CHK("detect cleared", det, 0);
    $display("test recovery done");
    close_out();
  end
endmodule // tb
